// ===== core/pport_pkg.sv
// Purpose: shared constants of the display module parallel port
// Assumes: 32-bit Avalon-MM register bus with byte addresses
// Notes: offsets are byte addresses, one aligned word per register

package pport_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [31:0] command_offset = 32'h8003_0058;
    localparam logic [31:0] capture_offset = 32'h8003_005C;
    localparam logic [31:0] control_offset = 32'h8003_00F0;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int byte_lsb = 0;
    localparam int byte_msb = 7;
    localparam int read_select_bit = 8;
    localparam int preload_lsb = 16;
    localparam int preload_msb = 19;
    localparam int strobe_start_lsb = 20;
    localparam int strobe_start_msb = 23;
    localparam int enable_bit = 0;
    localparam int busy_bit = 1;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [31:0] command_reset = 32'h0000_0000;
    localparam logic [31:0] capture_reset = 32'h0000_0000;
    localparam logic [31:0] control_reset = 32'h0000_0000;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam logic [3:0] count_zero = 4'h0;
    localparam logic [3:0] count_step = 4'h1;

endpackage

// ===== core/display_module_parallel_port.sv
// Purpose: software driven 8-bit parallel port to a character display module
// Assumes: one 50 MHz clock, synchronous active high reset, Avalon-MM slave
// Notes: bus lines are the reused sync, blank and low pixel pins
//
// Contract
// R1: command write starts one cycle; read-select 0 gives write, 1 gives read
// R2: commands start cycles only while the port enable bit is set
// R3: write data drive vsync, hsync, blank, pixel17/bias, pixel3..0, msb first
// R4: strobe goes high when the down counter reaches the strobe start value
// R5: in write cycles the data buffer enable rises with the strobe
// R6: strobe drops before count zero; data stays driven through count zero
// R7: each command loads the counter with the preload value, then counts down
// R8: preload minus strobe start sets the setup time before strobe rises
// R9: read cycles capture the eight lines on the strobe falling edge
// R10: captured data are read only; writes never alter them
// R11: reserved bits of both port registers carry no meaning when read
// R12: after count zero the counter stops, buffer releases, port goes idle

`timescale 1ns/1ps

module display_module_parallel_port
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [7:0] port_byte_in,
    output logic [7:0] port_byte_out,
    output logic port_byte_oe,
    output logic enable_strobe
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_value,
        input logic [31:0] new_value,
        input logic [3:0] lanes
    );
        logic [31:0] result;
        result = old_value;
        for (int i = 0; i < 4; i++)
        begin
            if (lanes[i])
            begin
                result[i*8 +: 8] = new_value[i*8 +: 8];
            end
        end
        return result;
    endfunction

    // ****************************************************************
    // pin synchroniser
    // ****************************************************************
    logic [7:0] byte_meta;
    logic [7:0] byte_sync;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            byte_meta <= 8'h00;
            byte_sync <= 8'h00;
        end
        else
        begin
            byte_meta <= port_byte_in;
            byte_sync <= byte_meta;
        end
    end

    // ****************************************************************
    // bus slave
    // ****************************************************************
    logic [31:0] command_reg;
    logic [31:0] capture_reg;
    logic port_enable;
    logic busy;
    logic is_read_cycle;
    logic [3:0] count;
    logic [7:0] captured_byte;
    logic hit_command;
    logic hit_capture;
    logic hit_control;
    logic stall;
    logic accept;
    logic write_done;
    logic start;
    logic [3:0] preload;
    logic [3:0] strobe_start;
    logic [31:0] next_readdata;
    logic [31:0] merged_command;

    assign merged_command = merge_bytes(command_reg, writedata, byteenable);
    assign hit_command = (address == pport_pkg::command_offset);
    assign hit_capture = (address == pport_pkg::capture_offset);
    assign hit_control = (address == pport_pkg::control_offset);
    // a second command must wait for the running cycle to finish
    assign stall = write && hit_command && busy;
    assign accept = (read || write) && waitrequest && !stall;
    assign write_done = write && !waitrequest;
    assign start = write_done && hit_command && port_enable && !busy; // see R1, see R2
    assign preload = capture_reg[pport_pkg::preload_msb:pport_pkg::preload_lsb];
    assign strobe_start = capture_reg[pport_pkg::strobe_start_msb:pport_pkg::strobe_start_lsb];

    always_comb
    begin
        next_readdata = 32'h0000_0000;
        // reserved bits read as zero
        if (hit_command) // see R11
        begin
            next_readdata[pport_pkg::byte_msb:pport_pkg::byte_lsb] = command_reg[7:0];
            next_readdata[pport_pkg::read_select_bit] = command_reg[pport_pkg::read_select_bit];
        end
        else if (hit_capture) // see R11
        begin
            next_readdata[pport_pkg::byte_msb:pport_pkg::byte_lsb] = captured_byte;
            next_readdata[pport_pkg::preload_msb:pport_pkg::preload_lsb] = preload;
            next_readdata[pport_pkg::strobe_start_msb:pport_pkg::strobe_start_lsb] = strobe_start;
        end
        else if (hit_control)
        begin
            next_readdata[pport_pkg::enable_bit] = port_enable;
            next_readdata[pport_pkg::busy_bit] = busy;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end
        else if (!waitrequest)
        begin
            waitrequest <= 1'b1;
        end
        else if (accept)
        begin
            waitrequest <= 1'b0;
            readdata <= next_readdata;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            command_reg <= pport_pkg::command_reset;
            capture_reg <= pport_pkg::capture_reset;
            port_enable <= pport_pkg::control_reset[pport_pkg::enable_bit];
        end
        else if (write_done)
        begin
            if (hit_command)
            begin
                command_reg <= merged_command;
            end
            if (hit_capture)
            begin
                // every enabled byte lane is stored here; only the count fields take effect
                capture_reg <= merge_bytes(capture_reg, writedata, byteenable);
            end
            if (hit_control && byteenable[0])
            begin
                port_enable <= writedata[pport_pkg::enable_bit];
            end
        end
    end

    // ****************************************************************
    // cycle sequencer
    // ****************************************************************
    logic [3:0] next_count;
    logic next_busy;
    logic next_strobe;
    logic next_oe;
    logic next_is_read;

    always_comb
    begin
        next_count = count;
        next_busy = busy;
        next_is_read = is_read_cycle;
        if (start)
        begin
            next_count = preload; // see R7
            next_busy = 1'b1;
            next_is_read = merged_command[pport_pkg::read_select_bit]; // see R1
        end
        else if (busy)
        begin
            if (count == pport_pkg::count_zero)
            begin
                next_busy = 1'b0; // see R12
            end
            else
            begin
                next_count = count - pport_pkg::count_step;
            end
        end
        // strobe covers counts strobe_start..1; setup is the gap from preload, see R8
        next_strobe = next_busy && (next_count <= strobe_start) && (next_count != pport_pkg::count_zero); // see R4, see R6
        // buffer follows the strobe and holds one more clock at count zero
        next_oe = next_busy && !next_is_read && (next_count <= strobe_start); // see R5, see R6
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            count <= pport_pkg::count_zero;
            busy <= 1'b0;
            is_read_cycle <= 1'b0;
            enable_strobe <= 1'b0;
            port_byte_oe <= 1'b0;
        end
        else
        begin
            count <= next_count;
            busy <= next_busy;
            is_read_cycle <= next_is_read;
            enable_strobe <= next_strobe;
            port_byte_oe <= next_oe;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            port_byte_out <= 8'h00;
        end
        else if (start)
        begin
            // bit 7 vsync, 6 hsync, 5 blank, 4 pixel17/bias, 3..0 pixels
            port_byte_out <= merged_command[pport_pkg::byte_msb:pport_pkg::byte_lsb]; // see R3
        end
    end

    // ****************************************************************
    // read capture
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            captured_byte <= pport_pkg::capture_reset[7:0];
        end
        else if (busy && is_read_cycle && enable_strobe && !next_strobe)
        begin
            // lines seen two clocks late through the synchroniser
            captured_byte <= byte_sync; // see R9, see R10
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_start_loads_count: // see R7
    assert property (@(posedge clock) disable iff (srst)
        start |=> busy && count == $past(preload))
    else $error("counter not loaded with preload on command");

    a_disabled_no_cycle: // see R2
    assert property (@(posedge clock) disable iff (srst)
        (write_done && hit_command && !port_enable && !busy) |=> !busy)
    else $error("cycle started while port disabled");

    a_strobe_at_start: // see R4
    assert property (@(posedge clock) disable iff (srst)
        (busy && count <= strobe_start && count != 4'h0) |-> enable_strobe)
    else $error("strobe low inside its count window");

    a_buffer_with_strobe: // see R5
    assert property (@(posedge clock) disable iff (srst)
        ($rose(enable_strobe) && !is_read_cycle) |-> port_byte_oe)
    else $error("buffer enable did not rise with strobe");

    a_hold_one_clock: // see R6
    assert property (@(posedge clock) disable iff (srst)
        ($fell(enable_strobe) && busy && !is_read_cycle) |-> port_byte_oe && count == 4'h0 ##1 !port_byte_oe)
    else $error("write data hold clock missing");

    a_setup_gap: // see R8
    assert property (@(posedge clock) disable iff (srst)
        (start && preload > strobe_start) |=> !enable_strobe)
    else $error("strobe rose without setup gap");

    a_byte_on_lines: // see R3
    assert property (@(posedge clock) disable iff (srst)
        port_byte_oe |-> port_byte_out == command_reg[7:0])
    else $error("driven byte differs from command data");

    a_capture_on_fall: // see R9
    assert property (@(posedge clock) disable iff (srst)
        (busy && is_read_cycle && enable_strobe && !next_strobe) |=> captured_byte == $past(byte_sync))
    else $error("read data not captured on strobe fall");

    a_capture_read_only: // see R10
    assert property (@(posedge clock) disable iff (srst)
        (write_done && hit_capture && !(busy && is_read_cycle && enable_strobe)) |=> $stable(captured_byte))
    else $error("software write altered captured data");

    a_idle_after_zero: // see R12
    assert property (@(posedge clock) disable iff (srst)
        (busy && count == 4'h0 && !start) |=> !busy && !port_byte_oe && !enable_strobe)
    else $error("port not idle after zero count");

    a_read_never_drives: // see R1
    assert property (@(posedge clock) disable iff (srst)
        is_read_cycle |-> !port_byte_oe)
    else $error("buffer driven during read cycle");

endmodule

// ===== sim/display_module_model.sv
// Purpose: behavioural character display module on the parallel lines
// Assumes: lines have no pull-ups, so an undriven line toggles every clock
// Notes: latches write data on the strobe fall, answers reads while strobe is high

`timescale 1ns/1ps

module display_module_model
(
    input wire logic clock,
    input wire logic [7:0] port_byte_out,
    input wire logic port_byte_oe,
    input wire logic enable_strobe,
    input wire logic [7:0] read_byte,
    output logic [7:0] line_level,
    output logic [7:0] got_byte,
    output logic [31:0] got_cnt
);
    logic [7:0] float_val = 8'h55;
    logic [1:0] hold = 2'h0;
    logic strobe_was = 1'b0;

    initial got_byte = 8'h00;
    initial got_cnt = 32'h0000_0000;

    // hold covers the two-flop synchroniser ahead of the capture register
    always @(posedge clock)
    begin
        float_val <= ~float_val;
        if (enable_strobe && !port_byte_oe)
            hold <= 2'h3;
        else if (hold != 2'h0)
            hold <= hold - 2'h1;
    end

    always @(negedge clock)
    begin
        strobe_was <= enable_strobe;
        if (strobe_was && !enable_strobe && port_byte_oe)
        begin
            got_byte <= port_byte_out;
            got_cnt <= got_cnt + 32'h1;
        end
    end

    assign line_level = port_byte_oe ? port_byte_out :
                        ((enable_strobe || hold != 2'h0) ? read_byte : float_val);
endmodule

// ===== sim/display_module_parallel_port_test.sv
// Purpose: self-checking bench of the display module parallel port
// Assumes: Avalon-MM master tasks, 50 MHz clock, display model on the lines
// Notes: counts are taken on falling edges where registered outputs are settled

`timescale 1ns/1ps

module display_module_parallel_port_test;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] address = 32'h0;
    logic [31:0] writedata = 32'h0;
    logic [7:0] read_byte = 8'h00;
    logic [31:0] readdata, rd, got_cnt, c0;
    logic waitrequest, port_byte_oe, enable_strobe;
    logic [7:0] port_byte_in, port_byte_out, got_byte, b;
    logic [3:0] p, s;
    logic [3:0] plist [3] = '{4'h6, 4'hF, 4'h9};
    logic [3:0] slist [3] = '{4'h3, 4'h1, 4'h8};
    logic [7:0] blist [3] = '{8'hA5, 8'h5A, 8'h81};
    int error_cnt = 0;
    int n_compared = 0;
    int n_setup, n_st, n_oe, i;

    always #10 clock = ~clock;

    display_module_parallel_port i_display_module_parallel_port (.clock(clock), .srst(srst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .port_byte_in(port_byte_in), .port_byte_out(port_byte_out),
        .port_byte_oe(port_byte_oe), .enable_strobe(enable_strobe));

    display_module_model i_display_module_model (.clock(clock), .port_byte_out(port_byte_out),
        .port_byte_oe(port_byte_oe), .enable_strobe(enable_strobe), .read_byte(read_byte),
        .line_level(port_byte_in), .got_byte(got_byte), .got_cnt(got_cnt));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task close_out;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request stays up until a rising edge that samples waitrequest low
    // no cycle limit here: a stalled command waits, only the watchdog ends a hang
    task bus_access(input logic is_wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        writedata <= d;
        write <= is_wr;
        read <= !is_wr;
        do
        begin
            @(posedge clock);
        end
        while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task read_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
        bus_access(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    // observation window is long enough for the largest preload
    task run_cycle(input logic [31:0] cmd);
        logic seen;
        bus_access(1'b1, pport_pkg::command_offset, cmd);
        n_setup = 0;
        n_st = 0;
        n_oe = 0;
        seen = 1'b0;
        for (int k = 0; k < 20; k++)
        begin
            @(negedge clock);
            if (enable_strobe === 1'b1)
            begin
                seen = 1'b1;
                n_st++;
            end
            else if (!seen)
                n_setup++;
            if (port_byte_oe === 1'b1)
                n_oe++;
        end
    endtask

    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        read_chk("command reset", pport_pkg::command_offset, pport_pkg::command_reset);
        read_chk("capture reset", pport_pkg::capture_offset, pport_pkg::capture_reset);
        read_chk("control reset", pport_pkg::control_offset, pport_pkg::control_reset);
        bus_access(1'b1, 32'h8003_0000, 32'hFFFF_FFFF);
        read_chk("unmapped", 32'h8003_0000, 32'h0);
        $display("test reset_values done");
        bus_access(1'b1, pport_pkg::capture_offset, 32'h0036_0000);
        run_cycle(32'h0000_00A5);
        chk("strobe disabled", 32'h0, 32'(n_st));
        chk("oe disabled", 32'h0, 32'(n_oe));
        $display("test disabled_port done");
        bus_access(1'b1, pport_pkg::control_offset, 32'h0000_0001);
        for (i = 0; i < 3; i++)
        begin
            p = plist[i];
            s = slist[i];
            b = blist[i];
            bus_access(1'b1, pport_pkg::capture_offset, {8'h00, s, p, 16'h0000});
            run_cycle({24'h0, b});
            chk("setup cycles", 32'(p) - 32'(s), 32'(n_setup));
            chk("strobe cycles", 32'(s), 32'(n_st));
            chk("oe cycles", 32'(s) + 32'h1, 32'(n_oe));
            chk("written byte", {24'h0, b}, {24'h0, got_byte});
        end
        $display("test write_cycles done");
        c0 = got_cnt;
        bus_access(1'b1, pport_pkg::command_offset, 32'h0000_003C);
        bus_access(1'b1, pport_pkg::command_offset, 32'h0000_00C3);
        repeat (40) @(negedge clock);
        chk("write count", c0 + 32'h2, got_cnt);
        chk("last byte", 32'h0000_00C3, {24'h0, got_byte});
        $display("test back_to_back done");
        read_byte <= 8'h96;
        bus_access(1'b1, pport_pkg::capture_offset, 32'h0036_0000);
        run_cycle(32'h0000_0100);
        chk("oe in read", 32'h0, 32'(n_oe));
        chk("read strobe", 32'h3, 32'(n_st));
        read_chk("captured", pport_pkg::capture_offset, 32'h0036_0096);
        bus_access(1'b1, pport_pkg::capture_offset, 32'h0036_00FF);
        read_chk("capture kept", pport_pkg::capture_offset, 32'h0036_0096);
        $display("test read_cycle done");
        close_out;
    end

    initial
    begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        $display("[FAIL] run_time expected done seen timeout");
        close_out;
    end
endmodule
